// ---- common/glf_pkg.sv ----
// package for the guard lock supervisor: timing and state types
`default_nettype none
package glf_pkg;
	localparam int CLK_HZ = 50000000;
	localparam int TICK_US = 1000;
	localparam int TICK_DIV = (CLK_HZ / 1000000) * TICK_US;
	localparam logic [15:0] TICK_DIV_LAST = 16'(TICK_DIV - 1);
	localparam int MS_W = 16;
	localparam logic [MS_W-1:0] MS_ZERO = 16'h0000;
	localparam logic [MS_W-1:0] MS_ONE = 16'h0001;
	localparam logic [15:0] DIV_ZERO = 16'h0000;
	localparam int UNLOCK_MS_DEF = 500;
	localparam int FBK_MS_DEF = 100;

	typedef enum logic [2:0] {
		GLF_LOCKED = 3'b000,
		GLF_DELAY = 3'b001,
		GLF_RELEASED = 3'b011,
		GLF_RELOCK = 3'b010,
		GLF_FAULT = 3'b110
	} glf_state_e;

	typedef struct packed {
		glf_state_e st;
		logic [MS_W-1:0] dly;
		logic [MS_W-1:0] fbkCnt;
		logic fbkWait;
		logic fbkRef;
		logic driveOn;
		logic opened;
		logic missOpen;
		logic fbkErr;
		logic safe;
	} glf_core_s;

	typedef struct packed {
		logic [15:0] div;
		logic tick;
	} glf_tick_s;
endpackage
`default_nettype wire

// ---- common/glf_tick_if.sv ----
// interface carrying the millisecond tick between the divider and the core
`default_nettype none
interface glf_tick_if;
	logic tick;
	modport src (output tick);
	modport snk (input tick);
endinterface
`default_nettype wire

// ---- logic/glf_guard_lock.sv ----
// guard lock supervisor with mandatory gate opening
`default_nettype none
module glf_guard_lock (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic unlockReq,
	input wire logic lockFbk,
	input wire logic gateClosed,
	input wire logic cfgGateAbsent,
	input wire logic cfgMandatoryOpen,
	input wire logic cfgSpringLock,
	input wire logic cfgErrOutEn,
	input wire logic [glf_pkg::MS_W-1:0] cfgUnlockMs,
	input wire logic [glf_pkg::MS_W-1:0] cfgFbkMs,
	input wire logic errClear,
	output logic solenoid_drive_out,
	output logic safe_status_out,
	output logic solenoid_active_trace,
	output logic errorOut,
	output logic missOpenErr,
	output logic fbkTimeoutErr
);
	import glf_pkg::*;
	glf_tick_if tk ();
	glf_tick_div uTick (
		.clk(clk),
		.sys_rst(sys_rst),
		.tk(tk)
	);

	glf_core_s s_q;
	glf_core_s s_d;
	logic lockedNow;
	logic gateOk;
	logic anyErr;

	// feedback high means solenoid energised
	function automatic logic isLocked(input logic fbk, input logic spring);
		return spring ? ~fbk : fbk;
	endfunction

	always_comb begin
		lockedNow = isLocked(lockFbk, cfgSpringLock);
		gateOk = cfgGateAbsent | gateClosed;
	end

	always_comb begin
		s_d = s_q;
		// a drive change restarts the feedback watch
		if (s_q.fbkWait && lockFbk != s_q.fbkRef) begin
			s_d.fbkWait = 1'b0;
		end else if (s_q.fbkWait && tk.tick) begin
			if (s_q.fbkCnt >= cfgFbkMs) begin
				s_d.fbkErr = 1'b1;
				s_d.fbkWait = 1'b0;
			end else begin
				s_d.fbkCnt = s_q.fbkCnt + MS_ONE;
			end
		end
		if (!cfgGateAbsent && !gateClosed && s_q.driveOn) begin
			s_d.opened = 1'b1;
		end
		unique case (s_q.st)
			GLF_LOCKED: begin
				if (unlockReq) begin
					s_d.st = GLF_DELAY;
					s_d.dly = MS_ZERO;
					s_d.opened = 1'b0;
				end
			end
			GLF_DELAY: begin
				if (!unlockReq) begin
					s_d.st = GLF_RELOCK;
				end else if (s_q.dly >= cfgUnlockMs) begin
					s_d.st = GLF_RELEASED;
					s_d.driveOn = 1'b1;
					s_d.fbkWait = 1'b1;
					s_d.fbkCnt = MS_ZERO;
					s_d.fbkRef = lockFbk;
				end else if (tk.tick) begin
					s_d.dly = s_q.dly + MS_ONE;
				end
			end
			GLF_RELEASED: begin
				if (!unlockReq && gateOk) begin
					s_d.st = GLF_RELOCK;
					s_d.driveOn = 1'b0;
					s_d.fbkWait = 1'b1;
					s_d.fbkCnt = MS_ZERO;
					s_d.fbkRef = lockFbk;
				end
			end
			GLF_RELOCK: begin
				if (lockedNow && gateOk && !s_q.fbkWait) begin
					s_d.st = GLF_LOCKED;
					// only a cycle whose unlock delay ran out (dly reached cfgUnlockMs) counts
					if (cfgMandatoryOpen && !cfgGateAbsent && s_q.dly >= cfgUnlockMs
						&& !s_q.opened && !s_d.opened) begin
						s_d.missOpen = 1'b1;
					end
				end
			end
			GLF_FAULT: begin
				if (lockedNow && gateOk) begin
					s_d.st = GLF_LOCKED;
				end
			end
			default: s_d.st = GLF_FAULT;
		endcase
		// timeout and missing-opening errors are sticky; a new error in the clear cycle wins
		if (errClear && !(s_d.fbkErr && !s_q.fbkErr)) begin
			s_d.fbkErr = 1'b0;
		end
		if (errClear && !(s_d.missOpen && !s_q.missOpen)) begin
			s_d.missOpen = 1'b0;
		end
		s_d.safe = (s_d.st == GLF_LOCKED) && lockedNow && gateOk
			&& !s_d.fbkErr && !s_d.missOpen;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign anyErr = s_q.fbkErr | s_q.missOpen | (s_q.st == GLF_LOCKED && !gateOk);
	// spring type: energising the solenoid unlocks, so drive equals release
	assign solenoid_drive_out = cfgSpringLock ? s_q.driveOn : ~s_q.driveOn;
	assign solenoid_active_trace = s_q.driveOn;
	assign safe_status_out = s_q.safe;
	assign errorOut = cfgErrOutEn & anyErr;
	assign missOpenErr = s_q.missOpen;
	assign fbkTimeoutErr = s_q.fbkErr;

	AST_SAFE_NEEDS_CLOSED: assert property (@(posedge clk) disable iff (sys_rst)
		safe_status_out |-> (s_q.st == GLF_LOCKED)) else $error("safe while not locked");
	AST_REQ_DROPS_SAFE: assert property (@(posedge clk) disable iff (sys_rst)
		unlockReq && s_q.st == GLF_LOCKED |=> !safe_status_out)
		else $error("safe stayed high on request");
	AST_NO_EARLY_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(s_q.driveOn) |-> $past(s_q.st) == GLF_DELAY && $past(s_q.dly) >= $past(cfgUnlockMs))
		else $error("drive before delay");
	AST_ERR_KILLS_SAFE: assert property (@(posedge clk) disable iff (sys_rst)
		(s_q.fbkErr || s_q.missOpen) |-> !safe_status_out) else $error("safe during error");
	AST_FBK_TIMEOUT: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(s_q.fbkErr) |-> $past(s_q.fbkWait) && $past(s_q.fbkCnt) >= $past(cfgFbkMs))
		else $error("timeout without wait");
	AST_RELOCK: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_RELEASED && !unlockReq && gateOk |=> !s_q.driveOn)
		else $error("no relock");
	AST_MISS_OPEN: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(s_q.missOpen) |-> $past(s_q.st) == GLF_RELOCK && s_q.st == GLF_LOCKED)
		else $error("miss-open outside cycle end");
	AST_ERR_EN: assert property (@(posedge clk) disable iff (sys_rst)
		!cfgErrOutEn |-> !errorOut) else $error("error output not gated");
	AST_CANCEL: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_DELAY && !unlockReq |=> !s_q.driveOn [*2])
		else $error("cancel failed");
	AST_SAFE_GATE: assert property (@(posedge clk) disable iff (sys_rst)
		safe_status_out
		|-> $past(gateOk))
		else $error("safe with gate open");
	AST_SAFE_LOCK: assert property (@(posedge clk) disable iff (sys_rst)
		safe_status_out
		|-> $past(lockedNow))
		else $error("safe with lock released");
	AST_SAFE_NO_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
		safe_status_out
		|-> !solenoid_active_trace)
		else $error("safe while release commanded");
	AST_REQ_TAKEN: assert property (@(posedge clk) disable iff (sys_rst)
		unlockReq && s_q.st == GLF_LOCKED
		|=> s_q.st == GLF_DELAY)
		else $error("request not taken");
	AST_NO_REQ_STAY: assert property (@(posedge clk) disable iff (sys_rst)
		!unlockReq && s_q.st == GLF_LOCKED
		|=> s_q.st == GLF_LOCKED)
		else $error("left locked without request");
	AST_DELAY_NOT_SAFE: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_DELAY
		|-> !safe_status_out)
		else $error("safe during unlock delay");
	AST_RELEASED_STATE: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_RELEASED
		|-> !safe_status_out && solenoid_active_trace)
		else $error("released state inconsistent");
	AST_DELAY_NO_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_DELAY
		|-> !solenoid_active_trace)
		else $error("drive during unlock delay");
	AST_DELAY_HOLDS: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_DELAY && unlockReq && s_q.dly < cfgUnlockMs
		|=> s_q.st == GLF_DELAY)
		else $error("delay left early");
	AST_DELAY_DONE: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_DELAY && unlockReq && s_q.dly >= cfgUnlockMs
		|=> solenoid_active_trace)
		else $error("no release after delay");
	AST_DELAY_STEP: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_DELAY && unlockReq && s_q.dly < cfgUnlockMs && tk.tick
		|=> s_q.dly == $past(s_q.dly) + MS_ONE)
		else $error("delay count skipped a tick");
	AST_GATE_DROPS_SAFE: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_LOCKED && !gateOk
		|=> !safe_status_out)
		else $error("safe with gate open while locked");
	AST_FBK_ARM: assert property (@(posedge clk) disable iff (sys_rst)
		$changed(solenoid_active_trace)
		|-> s_q.fbkWait && s_q.fbkCnt == MS_ZERO)
		else $error("feedback watch not armed");
	AST_FBK_REF: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(solenoid_active_trace)
		|-> s_q.fbkRef == $past(lockFbk))
		else $error("feedback reference wrong");
	AST_FBK_SEEN: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.fbkWait && lockFbk != s_q.fbkRef
		|=> !s_q.fbkWait || $changed(solenoid_active_trace))
		else $error("feedback change missed");
	AST_FBK_STICKY: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.fbkErr && !errClear
		|=> s_q.fbkErr)
		else $error("timeout error lost");
	AST_FBK_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
		errClear && !s_q.fbkWait
		|=> !s_q.fbkErr)
		else $error("timeout error not cleared");
	AST_RELOCK_NO_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_RELOCK
		|-> !solenoid_active_trace)
		else $error("drive during relock");
	AST_HOLD_REQ: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_RELEASED && unlockReq
		|=> solenoid_active_trace)
		else $error("relock with request held");
	AST_HOLD_GATE: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_RELEASED && !gateOk
		|=> solenoid_active_trace)
		else $error("relock with gate open");
	AST_DRIVE_FALL: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(s_q.driveOn)
		|-> $past(s_q.st) == GLF_RELEASED && !$past(unlockReq))
		else $error("drive dropped outside relock");
	AST_SAFE_RETURN: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_RELOCK && !s_q.fbkWait && lockedNow && gateOk
		|=> safe_status_out || missOpenErr || fbkTimeoutErr)
		else $error("safe not restored after relock");
	AST_LOCKED_SAFE: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_LOCKED && !unlockReq && lockedNow && gateOk && !anyErr
		|=> safe_status_out)
		else $error("safe not high while locked");
	AST_MISS_MODE: assert property (@(posedge clk) disable iff (sys_rst)
		$rose(s_q.missOpen)
		|-> $past(cfgMandatoryOpen) && !$past(cfgGateAbsent))
		else $error("missing-opening error outside its mode");
	AST_OPENED_NO_MISS: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_RELOCK && s_q.opened && !s_q.missOpen
		|=> !s_q.missOpen)
		else $error("error despite gate opening");
	AST_OPEN_SEEN: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_RELEASED && !cfgGateAbsent && !gateClosed
		|=> s_q.opened)
		else $error("gate opening not recorded");
	AST_OPEN_RESTART: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_LOCKED && unlockReq
		|=> !s_q.opened)
		else $error("old gate opening carried over");
	AST_MISS_STICKY: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.missOpen && !errClear
		|=> s_q.missOpen)
		else $error("missing-opening error lost");
	AST_MISS_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
		errClear && s_q.st != GLF_RELOCK
		|=> !s_q.missOpen)
		else $error("missing-opening error not cleared");
	AST_MISS_SET: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_RELOCK && !s_q.fbkWait && lockedNow && gateOk && cfgMandatoryOpen
		&& !cfgGateAbsent && s_q.dly >= cfgUnlockMs && !s_q.opened
		|=> s_q.missOpen)
		else $error("missing opening not flagged");
	AST_ABSENT_NO_OPEN: assert property (@(posedge clk) disable iff (sys_rst)
		cfgGateAbsent && !s_q.opened
		|=> !s_q.opened)
		else $error("gate opening seen with gate absent");
	AST_ABSENT_NO_MISS: assert property (@(posedge clk) disable iff (sys_rst)
		cfgGateAbsent && !s_q.missOpen
		|=> !s_q.missOpen)
		else $error("missing-opening error with gate absent");
	AST_ABSENT_NO_GATE_ERR: assert property (@(posedge clk) disable iff (sys_rst)
		cfgGateAbsent && !s_q.fbkErr && !s_q.missOpen
		|-> !errorOut)
		else $error("gate error with gate absent");
	AST_CANCEL_STATE: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_DELAY && !unlockReq
		|=> s_q.st == GLF_RELOCK)
		else $error("cancel did not relock");
	AST_CANCEL_NO_MISS: assert property (@(posedge clk) disable iff (sys_rst)
		s_q.st == GLF_RELOCK && s_q.dly < cfgUnlockMs && !s_q.missOpen
		|=> !s_q.missOpen)
		else $error("cancelled cycle flagged");
endmodule
`default_nettype wire

// ---- logic/glf_tick_div.sv ----
// millisecond enable divider
`default_nettype none
module glf_tick_div (
	input wire logic clk,
	input wire logic sys_rst,
	glf_tick_if.src tk
);
	import glf_pkg::*;
	glf_tick_s s_q;
	glf_tick_s s_d;
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (s_q.div == TICK_DIV_LAST) begin
			s_d.div = DIV_ZERO;
			s_d.tick = 1'b1;
		end else begin
			s_d.div = s_q.div + 16'h0001;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign tk.tick = s_q.tick;
endmodule
`default_nettype wire

// ---- tb/glf_lock_model.sv ----
// solenoid model: feedback contacts follow the coil after a few cycles
`default_nettype none
module glf_lock_model (
	input wire logic clk,
	input wire logic coil,
	input wire logic stuck,
	output var logic lockFbk
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] pipe = 4'h0;
	initial lockFbk = 1'b0;
	// lag is far inside any nonzero timeout; stuck freezes the contacts
	always @(posedge clk) begin
		pipe <= {pipe[2:0], coil};
		if (!stuck)
			lockFbk <= pipe[3];
	end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the guard lock supervisor
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import glf_pkg::*;
	logic clk = 1'b0, sys_rst = 1'b1, req = 1'b0, gate = 1'b1, absent = 1'b0;
	logic mand = 1'b1, spring = 1'b1, errEn = 1'b1, clr = 1'b0, stuck = 1'b0;
	logic [MS_W-1:0] unlockMs = MS_ZERO;
	logic [MS_W-1:0] fbkMs = MS_ONE;
	logic fbk, drv, safe, act, errOut, miss, tmo;
	int errCount = 0, testsRun = 0;
	initial begin
		forever #10 clk = ~clk;
	end
	glf_guard_lock glf_guard_lock_inst (.clk(clk), .sys_rst(sys_rst), .unlockReq(req),
		.lockFbk(fbk), .gateClosed(gate), .cfgGateAbsent(absent), .cfgMandatoryOpen(mand),
		.cfgSpringLock(spring), .cfgErrOutEn(errEn), .cfgUnlockMs(unlockMs),
		.cfgFbkMs(fbkMs), .errClear(clr), .solenoid_drive_out(drv),
		.safe_status_out(safe), .solenoid_active_trace(act), .errorOut(errOut),
		.missOpenErr(miss), .fbkTimeoutErr(tmo));
	glf_lock_model glf_lock_model_inst (.clk(clk), .coil(drv), .stuck(stuck), .lockFbk(fbk));
	task automatic completeRun();
		$display("checks %0d mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic got, input logic exp);
		testsRun++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return safe;
			1: return drv;
			2: return fbk;
			3: return miss;
			default: return tmo;
		endcase
	endfunction
	// a bound that runs out ends the run at once
	task automatic waitFor(input int s, input logic v, input int lim);
		int n;
		n = 0;
		while (pick(s) !== v && n < lim) begin
			cyc(1);
			n++;
		end
		chk(pick(s), v);
		if (pick(s) !== v)
			completeRun();
	endtask
	task automatic unlockCycle(input logic open);
		req = 1'b1;
		cyc(2);
		chk(safe, 1'b0);
		waitFor(1, 1'b1, 60000);
		chk(act, 1'b1);
		waitFor(2, 1'b1, 20);
		if (open) begin
			gate = 1'b0;
			cyc(5);
			gate = 1'b1;
		end
		req = 1'b0;
		waitFor(1, 1'b0, 5);
		waitFor(2, 1'b0, 20);
	endtask
	task automatic clearErr();
		clr = 1'b1;
		cyc(2);
		clr = 1'b0;
		waitFor(0, 1'b1, 10);
	endtask
	initial begin
		cyc(10);
		chk(safe, 1'b0);
		sys_rst = 1'b0;
		waitFor(0, 1'b1, 5);
		unlockCycle(1'b1);
		waitFor(0, 1'b1, 10);
		chk(miss, 1'b0);
		unlockCycle(1'b0);
		waitFor(3, 1'b1, 10);
		chk(errOut, 1'b1);
		chk(safe, 1'b0);
		errEn = 1'b0;
		cyc(1);
		chk(errOut, 1'b0);
		clearErr();
		errEn = 1'b1;
		gate = 1'b0;
		cyc(2);
		chk(errOut, 1'b1);
		chk(safe, 1'b0);
		gate = 1'b1;
		waitFor(0, 1'b1, 5);
		// a long delay leaves room to withdraw the request
		unlockMs = 16'h0002;
		req = 1'b1;
		cyc(10);
		chk(drv, 1'b0);
		req = 1'b0;
		cyc(200);
		chk(drv, 1'b0);
		chk(miss, 1'b0);
		unlockMs = MS_ZERO;
		// a zero timeout trips at the first tick, which keeps the run short
		fbkMs = MS_ZERO;
		stuck = 1'b1;
		req = 1'b1;
		waitFor(4, 1'b1, 60000);
		chk(safe, 1'b0);
		chk(errOut, 1'b1);
		stuck = 1'b0;
		fbkMs = MS_ONE;
		waitFor(2, 1'b1, 20);
		gate = 1'b0;
		cyc(2);
		gate = 1'b1;
		req = 1'b0;
		waitFor(2, 1'b0, 20);
		clearErr();
		absent = 1'b1;
		gate = 1'b0;
		cyc(3);
		chk(errOut, 1'b0);
		chk(safe, 1'b1);
		spring = 1'b0;
		cyc(2);
		chk(drv, 1'b1);
		waitFor(0, 1'b1, 10);
		completeRun();
	end
endmodule
`default_nettype wire
